// ### src/servo_status_display.sv
// Purpose: Front-panel status segments, status code and utility select
// Assumes: Drive state arrives asynchronously and is synchronised here
// Notes:   Signed 16-bit speeds and errors; magnitudes compared
//
// How it works
// - Control-power segment lit whenever control power is present.
// - Baseblock segment lit while motor power blocked, off when servo on.
// - Speed mode: match lit when speed difference within window, default 10.
// - Force mode: speed-match segment always lit.
// - Position mode: done lit while error below window, default 7 pulses.
// - Motion segment lit when speed exceeds threshold, default 20.
// - Speed/force mode: speed-reference lit above motion threshold.
// - Speed/force mode: force-reference lit above 10 percent rated force.
// - Position mode: reference-pulse segment lit while pulses arrive.
// - Position mode: error-clear segment follows the clear input.
// - Power-ready lit when main power on and normal.
// - Baseblock code while servo off.
// - Run code while servo on.
// - Forward-prohibited code when forward limit input is off.
// - Reverse-prohibited code when reverse limit input is off.
// - Active alarm number replaces the status code.
// - Utility functions 00 to 14 hex, including history, jog, clear.
// - Locked parameters and protected functions refused, lock shown for refused functions only.
//
// Our own choices: the register addresses and the address-and-strobe port.
module servo_status_display
   import status_display_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire drive_state_t drive_in,
   input  wire logic [3:0]   reg_addr,
   input  wire logic [15:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [15:0]       reg_rdata,
   output segments_t         segments,
   output status_code_t      status_code,
   output logic [7:0]        alarm_number,
   output logic [7:0]        func_active,
   output logic              func_start,
   output logic              lock_shown,
   output logic              irq
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   drive_state_t sync_a;
   drive_state_t drv;

   // Two stages; only the second stage is read by logic
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_a <= '0;
         drv    <= '0;
      end else begin
         sync_a <= drive_in;
         drv    <= sync_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   ctrl_mode_t  mode;
   logic        lock;
   logic [15:0] spd_win;
   logic [15:0] pos_win;
   logic [15:0] mot_thr;
   logic [15:0] rated_frc;
   logic [IRQ_BITS-1:0] irq_mask;
   logic        refused;

   // Protected parameters refuse writes while locked
   always_ff @(posedge clk) begin
      if (rst) begin
         mode      <= MODE_SPEED;
         lock      <= 1'b0;
         spd_win   <= SPD_WIN_RESET;
         pos_win   <= POS_WIN_RESET;
         mot_thr   <= MOT_THR_RESET;
         rated_frc <= RATED_FRC_RESET;
         irq_mask  <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: begin
               lock <= reg_wdata[CTRL_LOCK_BIT];
               if (!lock && reg_wdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
                  mode <= ctrl_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
               end
            end
            REG_SPD_WIN:   if (!lock) spd_win   <= reg_wdata;
            REG_POS_WIN:   if (!lock) pos_win   <= reg_wdata;
            REG_MOT_THR:   if (!lock) mot_thr   <= reg_wdata;
            REG_RATED_FRC: if (!lock) rated_frc <= reg_wdata;
            REG_IRQ_MASK:  irq_mask <= reg_wdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Magnitude helpers
   function automatic logic [15:0] mag(input logic [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction

   logic [16:0] spd_diff;
   logic [15:0] spd_diff_mag;
   logic [31:0] frc_scaled;
   logic [31:0] frc_limit;

   // Difference widened so large opposite speeds cannot wrap
   always_comb begin
      spd_diff     = {drv.motor_speed[15], drv.motor_speed} - {drv.ref_speed[15], drv.ref_speed};
      if (spd_diff[16]) begin
         spd_diff_mag = (spd_diff < 17'h18001) ? 16'hFFFF : 16'(-spd_diff);
      end else begin
         spd_diff_mag = (spd_diff[15]) ? 16'hFFFF : spd_diff[15:0];
      end
      frc_scaled = 32'(mag(drv.ref_force)) * 32'(PERCENT_FULL);
      frc_limit  = 32'(rated_frc) * 32'(FRC_PERCENT);
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference pulse activity: held lit for a short window after a pulse
   logic        pulse_d;
   logic [15:0] pulse_cnt;

   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_d   <= 1'b0;
         pulse_cnt <= '0;
      end else begin
         pulse_d <= drv.cmd_pulse;
         if (drv.cmd_pulse != pulse_d) begin
            pulse_cnt <= PULSE_HOLD_CYC;
         end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Segment evaluation, fresh every cycle
   segments_t next_segments;

   always_comb begin
      next_segments.control_power      = drv.control_power_on;
      next_segments.baseblock          = !drv.servo_on;
      next_segments.motion_detect_flag = mag(drv.motor_speed) > mot_thr;
      next_segments.power_ready        = drv.main_power_ok;
      unique case (mode)
         MODE_SPEED: begin
            next_segments.match_done = spd_diff_mag <= spd_win;
            next_segments.ref_a      = mag(drv.ref_speed) > mot_thr;
            next_segments.ref_b      = frc_scaled > frc_limit;
         end
         MODE_FORCE: begin
            next_segments.match_done = 1'b1;
            next_segments.ref_a      = mag(drv.ref_speed) > mot_thr;
            next_segments.ref_b      = frc_scaled > frc_limit;
         end
         MODE_POSITION: begin
            next_segments.match_done = mag(drv.pos_error) < pos_win;
            next_segments.ref_a      = pulse_cnt != '0;
            next_segments.ref_b      = drv.err_clear;
         end
         default: begin
            next_segments.match_done = 1'b0;
            next_segments.ref_a      = 1'b0;
            next_segments.ref_b      = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Status code: alarm, then limits, then run or baseblock
   status_code_t next_code;

   always_comb begin
      if (drv.alarm_active) begin
         next_code = CODE_ALARM;
      end else if (!drv.fwd_travel_limit) begin
         next_code = CODE_FWD_LIMIT;
      end else if (!drv.rev_travel_limit) begin
         next_code = CODE_REV_LIMIT;
      end else if (drv.servo_on) begin
         next_code = CODE_RUN;
      end else begin
         next_code = CODE_BASEBLOCK;
      end
   end

   // Indication registered straight from current state
   always_ff @(posedge clk) begin
      if (rst) begin
         segments     <= '0;
         status_code  <= CODE_BASEBLOCK;
         alarm_number <= '0;
      end else begin
         segments     <= next_segments;
         status_code  <= next_code;
         alarm_number <= drv.alarm_active ? drv.alarm_number : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Utility function selection
   logic fn_ok;
   logic fn_locked;

   always_comb begin
      fn_ok     = (reg_wdata[7:0] <= FN_LAST) && FN_EXISTS[reg_wdata[4:0]];
      fn_locked = fn_ok && lock && FN_PROTECTED[reg_wdata[4:0]];
      refused   = reg_wr && reg_addr == REG_FUNC_SEL && fn_locked;
   end

   // Start pulses one cycle; a refused start shows the lock instead
   always_ff @(posedge clk) begin
      if (rst) begin
         func_active <= FN_ALARM_HISTORY_VIEW;
         func_start  <= 1'b0;
         lock_shown  <= 1'b0;
      end else begin
         func_start <= 1'b0;
         if (reg_wr && reg_addr == REG_FUNC_SEL && fn_ok) begin
            lock_shown <= fn_locked;
            if (!fn_locked) begin
               func_active <= reg_wdata[7:0];
               func_start  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, cleared by reading, set wins over clear
   logic [IRQ_BITS-1:0] irq_stat;
   logic [IRQ_BITS-1:0] irq_set;
   logic                limit_now;
   logic                limit_d;
   logic                alarm_d;

   always_comb begin
      limit_now            = next_code == CODE_FWD_LIMIT || next_code == CODE_REV_LIMIT;
      irq_set              = '0;
      irq_set[IRQ_ALARM]   = drv.alarm_active && !alarm_d;
      irq_set[IRQ_LIMIT]   = limit_now && !limit_d;
      irq_set[IRQ_LOCKED]  = refused;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat <= '0;
         alarm_d  <= 1'b0;
         limit_d  <= 1'b0;
         irq      <= 1'b0;
      end else begin
         alarm_d <= drv.alarm_active;
         limit_d <= limit_now;
         if (reg_rd && reg_addr == REG_IRQ_STAT) begin
            irq_stat <= irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq <= |((irq_stat | irq_set) & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port: data valid the cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL:      reg_rdata <= 16'({lock, mode});
            REG_SPD_WIN:   reg_rdata <= spd_win;
            REG_POS_WIN:   reg_rdata <= pos_win;
            REG_MOT_THR:   reg_rdata <= mot_thr;
            REG_RATED_FRC: reg_rdata <= rated_frc;
            REG_SEGMENTS:  reg_rdata <= 16'(segments);
            REG_CODE:      reg_rdata <= {alarm_number, 5'h00, status_code};
            REG_FUNC_SEL:  reg_rdata <= 16'(func_active);
            REG_FUNC_STAT: reg_rdata <= 16'(lock_shown);
            REG_IRQ_STAT:  reg_rdata <= 16'(irq_stat);
            REG_IRQ_MASK:  reg_rdata <= 16'(irq_mask);
            default:       reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// ### src/status_display_pkg.sv
// Purpose: Shared constants and types for the servo status display block
// Assumes: 20 MHz clock, signed 16-bit speed and force quantities
// Notes:   Register offsets are word addresses on the plain register port
package status_display_pkg;

   // Register map (word index on the plain port)
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_SPD_WIN    = 4'h1;
   localparam logic [3:0] REG_POS_WIN    = 4'h2;
   localparam logic [3:0] REG_MOT_THR    = 4'h3;
   localparam logic [3:0] REG_RATED_FRC  = 4'h4;
   localparam logic [3:0] REG_SEGMENTS   = 4'h5;
   localparam logic [3:0] REG_CODE       = 4'h6;
   localparam logic [3:0] REG_FUNC_SEL   = 4'h7;
   localparam logic [3:0] REG_FUNC_STAT  = 4'h8;
   localparam logic [3:0] REG_IRQ_STAT   = 4'h9;
   localparam logic [3:0] REG_IRQ_MASK   = 4'hA;

   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LOCK_BIT = 2;

   // Reset values (speed in mm/s, position in pulses)
   localparam logic [15:0] SPD_WIN_RESET   = 16'h000A;
   localparam logic [15:0] POS_WIN_RESET   = 16'h0007;
   localparam logic [15:0] MOT_THR_RESET   = 16'h0014;
   localparam logic [15:0] RATED_FRC_RESET = 16'h03E8;
   localparam logic [15:0] FRC_PERCENT     = 16'h000A;
   localparam logic [15:0] PERCENT_FULL    = 16'h0064;

   // Utility function numbers
   localparam logic [7:0] FN_LAST                 = 8'h14;
   localparam logic [7:0] FN_ALARM_HISTORY_VIEW   = 8'h00;
   localparam logic [7:0] FN_JOG_FUNCTION         = 8'h02;
   localparam logic [7:0] FN_PARAMETER_LOCK       = 8'h10;
   localparam logic [7:0] FN_MODULE_DETECT_CLEAR  = 8'h14;
   // Functions that the lock protects, one bit per number 00..14
   localparam logic [20:0] FN_PROTECTED = 21'h18FFEE;
   localparam logic [20:0] FN_EXISTS    = 21'h1FFFEF;

   // Command pulse activity window: 1 ms at 20 MHz
   localparam int PULSE_HOLD_NS = 1000000;
   localparam int CLK_NS        = 50;
   localparam logic [15:0] PULSE_HOLD_CYC = 16'(PULSE_HOLD_NS / CLK_NS);

   // Interrupt status bits
   localparam int IRQ_ALARM  = 0;
   localparam int IRQ_LIMIT  = 1;
   localparam int IRQ_LOCKED = 2;
   localparam int IRQ_BITS   = 3;

   typedef enum logic [1:0] {
      MODE_SPEED    = 2'h0,
      MODE_FORCE    = 2'h1,
      MODE_POSITION = 2'h2
   } ctrl_mode_t;

   typedef enum logic [2:0] {
      CODE_BASEBLOCK = 3'h0,
      CODE_RUN       = 3'h1,
      CODE_FWD_LIMIT = 3'h2,
      CODE_REV_LIMIT = 3'h3,
      CODE_ALARM     = 3'h4
   } status_code_t;

   // Seven panel segments
   typedef struct packed {
      logic power_ready;
      logic ref_b;        // Force reference / error clear
      logic ref_a;        // Speed reference / reference pulse
      logic motion_detect_flag;
      logic match_done;   // Speed match / positioning done
      logic baseblock;
      logic control_power;
   } segments_t;

   // Drive state inputs
   typedef struct packed {
      logic        control_power_on;
      logic        main_power_ok;
      logic        servo_on;
      logic        fwd_travel_limit;  // 1 = travel allowed
      logic        rev_travel_limit;
      logic        alarm_active;
      logic [7:0]  alarm_number;
      logic        cmd_pulse;
      logic        err_clear;
      logic [15:0] motor_speed;
      logic [15:0] ref_speed;
      logic [15:0] ref_force;
      logic [15:0] pos_error;
   } drive_state_t;

endpackage

// ### tb/panel_model.sv
// Purpose: Operator panel seen from the display block
// Assumes: One start pulse per accepted utility select
// Notes:   Counts starts so refused selects can be told apart
module panel_model
(
   input wire logic  clk,
   input wire logic  rst,
   input wire logic  func_start,
   input wire logic  lock_shown,
   output logic [7:0] starts,
   output logic       lock_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // Panel keeps what it was shown until reset
   always_ff @(posedge clk) begin
      if (rst) begin
         starts    <= 8'h00;
         lock_seen <= 1'b0;
      end else begin
         starts    <= starts + {7'h00, func_start};
         lock_seen <= lock_seen | lock_shown;
      end
   end
endmodule

// ### tb/status_display_checker.sv
// Purpose: Port assertions for the servo status display
// Assumes: Drive state reaches the outputs three edges after it changes
// Notes:   Mode-dependent segments are judged by the bench instead
module status_display_checker
   import status_display_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst,
   input wire drive_state_t drive_in,
   input wire logic         reg_rd,
   input wire logic [15:0]  reg_rdata,
   input wire segments_t    segments,
   input wire status_code_t status_code,
   input wire logic [7:0]   alarm_number,
   input wire logic         func_start,
   input wire logic         irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0]   settle;
   drive_state_t d1;
   drive_state_t d2;
   drive_state_t p;
   logic         ok;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Edges since reset; synchroniser holds stale zeros just after release
   always_ff @(posedge clk) begin
      if (rst) settle <= 3'h0;
      else if (settle != 3'h5) settle <= settle + 3'h1;
   end

   // Delay line matching the input-to-output latency
   always_ff @(posedge clk) begin
      d1 <= drive_in;
      d2 <= d1;
      p  <= d2;
   end
   assign ok = (settle == 3'h5);

   ////////////////////////////////////////////////////////////////////////
   AST_CTRL_POWER: assert property (ok |-> segments.control_power == p.control_power_on)
      else $error("control power segment wrong");
   AST_POWER_READY: assert property (ok |-> segments.power_ready == p.main_power_ok)
      else $error("power ready segment wrong");
   AST_BB_SEG: assert property (ok && p.servo_on |-> !segments.baseblock)
      else $error("baseblock segment lit with servo on");
   AST_ALARM: assert property (ok && p.alarm_active |->
      status_code == CODE_ALARM && alarm_number == p.alarm_number)
      else $error("alarm code wrong");
   AST_FWD: assert property (ok && !p.alarm_active && !p.fwd_travel_limit |->
      status_code == CODE_FWD_LIMIT) else $error("forward limit code missing");
   AST_REV: assert property (ok && !p.alarm_active && p.fwd_travel_limit
      && !p.rev_travel_limit |-> status_code == CODE_REV_LIMIT)
      else $error("reverse limit code missing");
   AST_RUN: assert property (ok && !p.alarm_active && p.fwd_travel_limit
      && p.rev_travel_limit && p.servo_on |-> status_code == CODE_RUN)
      else $error("run code missing");
   AST_BB_CODE: assert property (ok && !p.alarm_active && p.fwd_travel_limit
      && p.rev_travel_limit && !p.servo_on |-> status_code == CODE_BASEBLOCK)
      else $error("baseblock code missing");
   AST_RDATA_QUIET: assert property (ok && !$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");

   // Main scenarios reached
   cover property (status_code == CODE_ALARM);
   cover property (func_start);
   cover property (irq);
endmodule

bind servo_status_display status_display_checker chk (.clk(clk), .rst(rst),
   .drive_in(drive_in), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .segments(segments),
   .status_code(status_code), .alarm_number(alarm_number), .func_start(func_start),
   .irq(irq));

// ### tb/tb_servo_status_display.sv
// Purpose: Self-checking bench for the servo status display
// Assumes: Outputs settle three edges after a drive change; apply waits four
// Notes:   Random drive values sit near every threshold on purpose
module tb_servo_status_display import status_display_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   drive_state_t drive_in = '0;
   logic [3:0]   reg_addr = 4'h0;
   logic [15:0]  reg_wdata = 16'h0000;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [15:0]  reg_rdata, rv, thr;
   segments_t    segments;
   status_code_t status_code;
   logic [7:0]   alarm_number, func_active, starts, fa;
   logic         func_start, lock_shown, irq, lock_seen, en;
   ctrl_mode_t   mode;
   drive_state_t d;
   int           miscompares = 0;
   int           checks_done = 0;

   always #25 clk = ~clk;

   servo_status_display dut (.clk(clk), .rst(rst), .drive_in(drive_in),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .segments(segments), .status_code(status_code),
      .alarm_number(alarm_number), .func_active(func_active), .func_start(func_start),
      .lock_shown(lock_shown), .irq(irq));
   panel_model panel (.clk(clk), .rst(rst), .func_start(func_start),
      .lock_shown(lock_shown), .starts(starts), .lock_seen(lock_seen));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] mag(logic [15:0] v);
      return v[15] ? -v : v;
   endfunction
   // Expected panel from mode, drive state and motion threshold
   function automatic segments_t exp_seg(ctrl_mode_t m, drive_state_t s, logic [15:0] t);
      segments_t e;
      logic      pos;
      pos = (m == MODE_POSITION);
      e.control_power = s.control_power_on;
      e.baseblock = !s.servo_on;
      e.match_done = pos ? mag(s.pos_error) < 16'h0007
         : (m == MODE_FORCE) || mag(s.motor_speed - s.ref_speed) <= 16'h000A;
      e.motion_detect_flag = mag(s.motor_speed) > t;
      e.ref_a = pos ? 1'b0 : mag(s.ref_speed) > t;
      e.ref_b = pos ? s.err_clear : mag(s.ref_force) * 16'h0064 > 16'h2710;
      e.power_ready = s.main_power_ok;
      return e;
   endfunction
   // Code priority: alarm, forward, reverse, run, baseblock
   function automatic logic [15:0] exp_code(drive_state_t s);
      if (s.alarm_active) return {5'h00, s.alarm_number, CODE_ALARM};
      if (!s.fwd_travel_limit) return {13'h0000, CODE_FWD_LIMIT};
      if (!s.rev_travel_limit) return {13'h0000, CODE_REV_LIMIT};
      return {13'h0000, s.servo_on ? CODE_RUN : CODE_BASEBLOCK};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // Apply a drive state, let it settle, compare panel and code
   task automatic apply(drive_state_t s);
      @(posedge clk);
      drive_in <= s;
      repeat (4) @(posedge clk);
      #1;
      cmp("segments", 16'(exp_seg(mode, s, thr)), 16'(segments));
      cmp("code", exp_code(s), {5'h00, alarm_number, status_code});
   endtask
   task automatic end_sim();
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog well past the expected run length
   initial begin
      #2500000;
      miscompares++;
      end_sim();
   end

   initial begin
      thr = 16'h0014;
      void'($urandom(32'hE2B8A48C));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      cmp("reset code", 16'(CODE_BASEBLOCK), 16'(status_code));
      rd(REG_SPD_WIN, rv); cmp("speed window", 16'h000A, rv);
      rd(REG_POS_WIN, rv); cmp("position window", 16'h0007, rv);
      rd(REG_MOT_THR, rv); cmp("motion threshold", 16'h0014, rv);
      rd(4'hF, rv); cmp("unmapped", 16'h0000, rv);
      wr(REG_IRQ_MASK, 16'h0000);
      // Mode 3 is refused, so the last pass stays in position mode
      for (int m = 0; m < 4; m++) begin
         wr(REG_CTRL, 16'(m));
         mode = (m == 3) ? MODE_POSITION : ctrl_mode_t'(m);
         d = '0;
         d.control_power_on = 1'b1;
         d.fwd_travel_limit = 1'b1;
         d.rev_travel_limit = 1'b1;
         d.motor_speed = 16'h0014;
         d.ref_speed = 16'h001E;
         d.ref_force = 16'h0064;
         d.pos_error = 16'hFFF9;
         apply(d);
         repeat (30) begin
            d = 80'({$urandom, $urandom, $urandom});
            d.alarm_active = ($urandom_range(3) == 0);
            d.cmd_pulse = 1'b0;
            d.motor_speed = 16'($urandom_range(80)) - 16'h0028;
            d.ref_speed = d.motor_speed + 16'($urandom_range(24)) - 16'h000C;
            d.ref_force = 16'($urandom_range(240)) - 16'h0078;
            d.pos_error = 16'($urandom_range(16)) - 16'h0008;
            apply(d);
         end
      end
      cmp("irq masked", 16'h0000, 16'(irq));
      // Utility numbers, including gaps and beyond the last one
      fa = 8'h00;
      for (int n = 0; n < 8'h17; n++) begin
         wr(REG_FUNC_SEL, 16'(n));
         en = (n <= 8'h14) && (n != 8'h04);
         if (en) fa = 8'(n);
         cmp("func start", 16'(en), 16'(func_start));
         cmp("func active", 16'(fa), 16'(func_active));
      end
      cmp("panel starts", 16'h0014, 16'(starts));
      mode = MODE_SPEED;
      wr(REG_CTRL, 16'h0000);
      thr = 16'h000F;
      wr(REG_MOT_THR, thr);
      d.alarm_active = 1'b0;
      d.fwd_travel_limit = 1'b1;
      d.rev_travel_limit = 1'b1;
      d.motor_speed = 16'h0010;
      apply(d);
      rd(REG_IRQ_STAT, rv);
      wr(REG_IRQ_MASK, 16'h0007);
      d.alarm_active = 1'b1;
      d.alarm_number = 8'h3A;
      apply(d);
      cmp("irq alarm", 16'h0001, 16'(irq));
      rd(REG_IRQ_STAT, rv); cmp("irq stat", 16'h0001, rv & 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      cmp("irq cleared", 16'h0000, 16'(irq));
      rd(REG_CODE, rv); cmp("code reg", 16'h3A04, rv);
      // Lock: parameter write refused, protected select refused
      wr(REG_CTRL, 16'h0004);
      wr(REG_MOT_THR, 16'h0030);
      rd(REG_MOT_THR, rv); cmp("locked threshold", thr, rv);
      wr(REG_FUNC_SEL, 16'h0002);
      cmp("locked start", 16'h0000, 16'(func_start));
      cmp("lock shown", 16'h0001, 16'(lock_shown));
      @(posedge clk);
      #1;
      cmp("panel lock", 16'h0001, 16'(lock_seen));
      cmp("irq refused", 16'h0001, 16'(irq));
      wr(REG_FUNC_SEL, 16'h0013);
      cmp("locked 13 start", 16'h0000, 16'(func_start));
      rd(REG_FUNC_STAT, rv); cmp("func stat", 16'h0001, rv);
      wr(REG_FUNC_SEL, 16'h0010);
      cmp("free start", 16'h0001, 16'(func_start));
      // Position mode: pulse activity and error clear
      wr(REG_CTRL, 16'h0000);
      wr(REG_CTRL, 16'h0002);
      mode = MODE_POSITION;
      d.alarm_active = 1'b0;
      d.err_clear = 1'b1;
      d.cmd_pulse = 1'b1;
      @(posedge clk);
      drive_in <= d;
      repeat (4) @(posedge clk);
      #1;
      cmp("pulse seen", 16'h0001, 16'(segments.ref_a));
      cmp("error clear", 16'h0001, 16'(segments.ref_b));
      repeat (20010) @(posedge clk);
      #1;
      cmp("pulse gone", 16'h0000, 16'(segments.ref_a));
      end_sim();
   end
endmodule
